// file: gsms_top.sv
module gsms_top #(
  parameter logic [35:0] APD_CYCLES  = 36'(gsms_pkg::APD_CYC),
  parameter logic [27:0] HOLD_CYCLES = 28'(gsms_pkg::HOLD_CYC)
) (
  input  wire logic                      clk_sys,       // 100 MHz clock
  input  wire logic                      arst_n,        // async reset
  input  wire logic [gsms_pkg::NKEYS-1:0] key_pin,      // raw keypad pins
  input  wire logic signed [15:0]        force_val,     // signed reading
  input  wire logic                      load_change,   // load moved pulse
  input  wire logic                      comm_activity, // serial traffic pulse
  input  wire logic [11:0]               paddr,         // apb address
  input  wire logic                      psel,          // apb select
  input  wire logic                      penable,       // apb enable
  input  wire logic                      pwrite,        // apb direction
  input  wire logic [31:0]               pwdata,        // apb write data
  output logic [31:0]                    prdata,        // apb read data
  output logic                           pready,        // apb ready
  output logic                           pslverr,       // apb error
  output gsms_pkg::gsms_state_e          disp_step,     // prompt on display
  output logic                           disp_flash,    // prompt flashing
  output logic [2:0]                     disp_option,   // option code shown
  output logic                           buzzer,        // limit buzzer
  output logic                           stand_stop,    // stop to test stand
  output logic                           gauge_power,   // power held on
  output logic                           peak_clear,    // wipe peaks pulse
  output logic                           units_blank,   // two spaces for unit
  output gsms_pkg::gsms_comm_s           comm_cfg       // serial settings
);

  gsms_pkg::gsms_state_e st_q;
  gsms_pkg::gsms_comm_s  comm_q;
  logic [gsms_pkg::NKEYS-1:0] k_s1_q, k_s2_q, k_prev_q, k_edge;
  logic               flash_q, power_q, peak_clr_q;
  logic               buzz_en_q, stand_en_q, apd_en_q;
  logic               buzzer_q, stand_q;
  logic [2:0]         edit_q;
  logic [27:0]        hold_q;
  logic [35:0]        idle_q;
  logic signed [15:0] lim_hi_q, lim_lo_q;
  logic               hi_set_q, lo_set_q, lim_ok, hit_w;
  logic               accept, entry, apd_expire, activity;
  logic [31:0]        prdata_q, rd_mux;
  logic               rd_hit, wr_en;

  // two flops per key pin, then a third for edge detection
  generate
    for (genvar i = 0; i < gsms_pkg::NKEYS; i++) begin : g_key
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          k_s1_q[i]   <= 1'b0;
          k_s2_q[i]   <= 1'b0;
          k_prev_q[i] <= 1'b0;
        end else begin
          k_s1_q[i]   <= key_pin[i];
          k_s2_q[i]   <= k_s1_q[i];
          k_prev_q[i] <= k_s2_q[i];
        end
      end
      assign k_edge[i] = k_s2_q[i] & ~k_prev_q[i];
    end
  endgenerate

  // enter and send both accept in the baud, units, word and parity steps
  assign accept = k_edge[gsms_pkg::KEY_ENTER] | k_edge[gsms_pkg::KEY_SEND];
  assign entry  = k_s2_q[gsms_pkg::KEY_UP] &
                  k_edge[gsms_pkg::KEY_NEXT];
  assign lim_ok = hi_set_q & lo_set_q;

  // limit compare; tension is negative so low is the lower bound
  assign hit_w = lim_ok & power_q &
                 ((force_val >= lim_hi_q) || (force_val <= lim_lo_q));

  // outputs held for as long as the limit stays reached
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      buzzer_q <= 1'b0;
      stand_q  <= 1'b0;
    end else begin
      buzzer_q <= hit_w & buzz_en_q;
      stand_q  <= hit_w & stand_en_q;
    end
  end

  // idle timer; keys, load and traffic all restart it
  assign activity   = (|k_edge) | load_change | comm_activity;
  assign apd_expire = apd_en_q & power_q &
                      (idle_q == APD_CYCLES - 36'h0_0000_0001);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= '0;
    end else if (!power_q || activity || apd_expire) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + 36'h0_0000_0001;
    end
  end

  // send-key hold timer at power-on; saturates so it cannot wrap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= '0;
    end else if (st_q != gsms_pkg::ST_HOLD) begin
      hold_q <= '0;
    end else if (hold_q != HOLD_CYCLES) begin
      hold_q <= hold_q + 28'h000_0001;
    end
  end

  // peaks are lost on every power removal, manual or automatic
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      peak_clr_q <= 1'b0;
    end else begin
      peak_clr_q <= power_q &
                    (apd_expire | k_edge[gsms_pkg::KEY_OFF]);
    end
  end

  // menu sequencer; settings sit outside the power domain so they persist
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= gsms_pkg::ST_OFF;
      power_q    <= 1'b0;
      flash_q    <= 1'b0;
      edit_q     <= 3'h0;
      buzz_en_q  <= 1'b0;
      stand_en_q <= 1'b0;
      apd_en_q   <= 1'b0;
      comm_q     <= gsms_pkg::COMM_RST;
    end else if (power_q && (apd_expire || k_edge[gsms_pkg::KEY_OFF])) begin
      st_q    <= gsms_pkg::ST_OFF;
      power_q <= 1'b0;
      flash_q <= 1'b0;
    end else begin
      case (st_q)
        gsms_pkg::ST_OFF: begin
          if (k_edge[gsms_pkg::KEY_ON]) begin
            power_q <= 1'b1;
            st_q    <= k_s2_q[gsms_pkg::KEY_SEND] ? gsms_pkg::ST_HOLD
                                                  : gsms_pkg::ST_RUN;
          end
        end
        gsms_pkg::ST_HOLD: begin
          if (!k_s2_q[gsms_pkg::KEY_SEND]) begin
            if (hold_q == HOLD_CYCLES) begin
              st_q    <= gsms_pkg::ST_BCD;
              flash_q <= 1'b1;
            end else begin
              st_q    <= gsms_pkg::ST_RUN;
            end
          end
        end
        gsms_pkg::ST_RUN: begin
          // the chain is refused while any limit is still unset
          if (entry && lim_ok) begin
            st_q    <= gsms_pkg::ST_ALARM;
            flash_q <= 1'b1;
          end
        end
        gsms_pkg::ST_ALARM: begin
          if (k_edge[gsms_pkg::KEY_ENTER]) begin
            buzz_en_q <= 1'b1;
            flash_q   <= 1'b1;
            st_q      <= gsms_pkg::ST_STAND;
          end else if (k_edge[gsms_pkg::KEY_NEXT]) begin
            buzz_en_q <= 1'b0;
            flash_q   <= 1'b0;
            st_q      <= gsms_pkg::ST_STAND;
          end
        end
        gsms_pkg::ST_STAND: begin
          if (k_edge[gsms_pkg::KEY_ENTER]) begin
            stand_en_q <= 1'b1;
            flash_q    <= 1'b1;
            st_q       <= gsms_pkg::ST_APD;
          end else if (k_edge[gsms_pkg::KEY_NEXT]) begin
            stand_en_q <= 1'b0;
            flash_q    <= 1'b0;
            st_q       <= gsms_pkg::ST_APD;
          end
        end
        gsms_pkg::ST_APD: begin
          if (k_edge[gsms_pkg::KEY_ENTER] ||
              k_edge[gsms_pkg::KEY_NEXT]) begin
            apd_en_q <= k_edge[gsms_pkg::KEY_ENTER];
            flash_q  <= 1'b0;
            st_q     <= gsms_pkg::ST_RUN;
          end
        end
        gsms_pkg::ST_BCD: begin
          if (k_edge[gsms_pkg::KEY_ENTER]) begin
            comm_q.fmt <= gsms_pkg::FMT_BCD;
            flash_q    <= 1'b0;
            st_q       <= gsms_pkg::ST_RUN;
          end else if (k_edge[gsms_pkg::KEY_NEXT]) begin
            edit_q <= gsms_pkg::BAUD_19200;
            st_q   <= gsms_pkg::ST_BAUD;
          end
        end
        gsms_pkg::ST_BAUD: begin
          if (accept) begin
            comm_q.baud <= edit_q;
            edit_q      <= {1'b0, comm_q.units};
            st_q        <= gsms_pkg::ST_UNITS;
          end else if (k_edge[gsms_pkg::KEY_NEXT]) begin
            edit_q <= (edit_q == gsms_pkg::BAUD_LAST) ? gsms_pkg::BAUD_19200
                                                      : edit_q + 3'h1;
          end
        end
        gsms_pkg::ST_UNITS: begin
          // units code picks between the two serial formats
          if (accept) begin
            comm_q.units <= edit_q[1:0];
            comm_q.fmt   <= (edit_q[1:0] == gsms_pkg::UNITS_NUM)
                            ? gsms_pkg::FMT_NUMERIC
                            : gsms_pkg::FMT_FULL;
            edit_q       <= {1'b0, comm_q.word};
            st_q         <= gsms_pkg::ST_WORD;
          end else if (k_edge[gsms_pkg::KEY_NEXT]) begin
            edit_q <= (edit_q[1:0] == gsms_pkg::UNITS_FULL)
                      ? {1'b0, gsms_pkg::UNITS_NUM}
                      : {1'b0, gsms_pkg::UNITS_FULL};
          end
        end
        gsms_pkg::ST_WORD: begin
          if (accept) begin
            comm_q.word <= edit_q[1:0];
            edit_q      <= {1'b0, comm_q.parity};
            st_q        <= gsms_pkg::ST_PARITY;
          end else if (k_edge[gsms_pkg::KEY_NEXT]) begin
            edit_q <= (edit_q[1:0] == gsms_pkg::WORD_LAST) ? 3'h0
                                                           : edit_q + 3'h1;
          end
        end
        gsms_pkg::ST_PARITY: begin
          if (accept) begin
            comm_q.parity <= edit_q[1:0];
            flash_q       <= 1'b0;
            st_q          <= gsms_pkg::ST_RUN;
          end else if (k_edge[gsms_pkg::KEY_NEXT]) begin
            edit_q <= (edit_q[1:0] == gsms_pkg::PAR_LAST) ? 3'h0
                                                          : edit_q + 3'h1;
          end
        end
        default: begin
          st_q <= gsms_pkg::ST_OFF;
        end
      endcase
    end
  end

  // apb slave: zero wait, unmapped addresses answer with pslverr
  assign wr_en = psel & penable & pwrite;
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      gsms_pkg::OFS_STATUS: rd_mux = {20'h0_0000, st_q, 2'h0, power_q,
                                      hit_w, flash_q, apd_en_q,
                                      stand_en_q, buzz_en_q};
      gsms_pkg::OFS_LIM_HI: rd_mux = {15'h0000, hi_set_q, lim_hi_q};
      gsms_pkg::OFS_LIM_LO: rd_mux = {15'h0000, lo_set_q, lim_lo_q};
      gsms_pkg::OFS_COMM:   rd_mux = {21'h00_0000, comm_q};
      gsms_pkg::OFS_CTRL:   rd_mux = 32'h0000_0000;
      default:              rd_hit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle so it stands through access
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // limit registers; a written limit counts as configured
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lim_hi_q <= gsms_pkg::LIM_RST;
      lim_lo_q <= gsms_pkg::LIM_RST;
      hi_set_q <= 1'b0;
      lo_set_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == gsms_pkg::OFS_LIM_HI) begin
        lim_hi_q <= pwdata[15:0];
        hi_set_q <= 1'b1;
      end else if (paddr == gsms_pkg::OFS_LIM_LO) begin
        lim_lo_q <= pwdata[15:0];
        lo_set_q <= 1'b1;
      end else if (paddr == gsms_pkg::OFS_CTRL &&
                   pwdata[gsms_pkg::CTRL_CLR_LIM]) begin
        hi_set_q <= 1'b0;
        lo_set_q <= 1'b0;
      end
    end
  end

  // outputs straight from registers, save pready and pslverr; units_blank decodes the comm register
  assign prdata      = prdata_q;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~rd_hit;
  assign disp_step   = st_q;
  assign disp_flash  = flash_q;
  assign disp_option = edit_q;
  assign buzzer      = buzzer_q;
  assign stand_stop  = stand_q;
  assign gauge_power = power_q;
  assign peak_clear  = peak_clr_q;
  assign units_blank = (comm_q.fmt == gsms_pkg::FMT_NUMERIC);
  assign comm_cfg    = comm_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // step checks exclude the off key and expiry, which win over any step

  chk_buzz_follows: assert property (
    (buzz_en_q && hit_w) |=> buzzer_q)
    else $error("buzzer silent at limit");
  chk_buzz_nolimit: assert property (
    !lim_ok |=> !buzzer_q && !stand_q)
    else $error("output without limits");
  chk_stop_disabled: assert property (
    !stand_en_q |=> !stand_q)
    else $error("stop while disabled");
  chk_alarm_enter: assert property (
    (st_q == gsms_pkg::ST_ALARM && k_edge[gsms_pkg::KEY_ENTER] &&
     !apd_expire && !k_edge[gsms_pkg::KEY_OFF])
    |=> st_q == gsms_pkg::ST_STAND && buzz_en_q && flash_q)
    else $error("alarm enter wrong");
  chk_alarm_next: assert property (
    (st_q == gsms_pkg::ST_ALARM && k_edge[gsms_pkg::KEY_NEXT] &&
     !k_edge[gsms_pkg::KEY_ENTER] && !k_edge[gsms_pkg::KEY_OFF] && !apd_expire)
    |=> !buzz_en_q && !flash_q)
    else $error("alarm next wrong");
  chk_stand_order: assert property (
    (st_q != gsms_pkg::ST_STAND) ##1 (st_q == gsms_pkg::ST_STAND)
    |-> $past(st_q) == gsms_pkg::ST_ALARM)
    else $error("stand step out of order");
  chk_apd_off: assert property (
    apd_expire |=> !power_q && peak_clr_q ##1 !peak_clr_q)
    else $error("power-down wrong");
  chk_bcd_select: assert property (
    (st_q == gsms_pkg::ST_BCD && k_edge[gsms_pkg::KEY_ENTER] &&
     !k_edge[gsms_pkg::KEY_OFF] && !apd_expire)
    |=> st_q == gsms_pkg::ST_RUN && comm_q.fmt == gsms_pkg::FMT_BCD &&
        !flash_q)
    else $error("bcd select wrong");
  chk_chain_refuse: assert property (
    (st_q == gsms_pkg::ST_RUN && !lim_ok) |=> st_q != gsms_pkg::ST_ALARM)
    else $error("chain entered without limits");
  chk_stop_follows: assert property (
    (stand_en_q && hit_w) |=> stand_q)
    else $error("stop not sent at limit");
  chk_off_wipe: assert property (
    (power_q && k_edge[gsms_pkg::KEY_OFF]) |=> !power_q && peak_clr_q)
    else $error("off key did not wipe peaks");
  chk_apd_choice: assert property (
    (st_q == gsms_pkg::ST_APD && k_edge[gsms_pkg::KEY_ENTER] &&
     !k_edge[gsms_pkg::KEY_OFF] && !apd_expire)
    |=> st_q == gsms_pkg::ST_RUN && apd_en_q)
    else $error("power-down choice wrong");

  cov_chain: cover property (
    st_q == gsms_pkg::ST_ALARM ##[1:1000] st_q == gsms_pkg::ST_APD);
  cov_menu: cover property (
    st_q == gsms_pkg::ST_PARITY ##1 st_q == gsms_pkg::ST_RUN);
  cov_stop: cover property (stand_q && buzzer_q);
  cov_wipe: cover property (peak_clr_q);
  cov_short_hold: cover property (
    st_q == gsms_pkg::ST_HOLD ##1 st_q == gsms_pkg::ST_RUN);

endmodule // gsms_top

// file: gsms_pkg.sv
// What this block does
// - buzzer, stand-stop and power-down are set in one chain of three steps
// - chain opens on up-arrow held plus next-option; alarm prompt flashes
// - enter at alarm prompt enables buzzer, flashes next prompt, goes on
// - next-option at alarm prompt disables buzzer, next prompt shown steady
// - chain refused until both limits are configured; else buzzer stays quiet
// - enabled buzzer sounds while force reaches high or low limit
// - enter at stand step enables stop output, halt prompt flashes
// - next-option at stand step disables stop output, halt prompt steady
// - stand step reached only after limits set and buzzer step done
// - enabled power-down after 10 idle minutes; activity restarts interval
// - any power removal clears all captured peaks
// - enter or next-option at power-down step sets it and ends chain
// - comm menu opens when send key held about 2 s at power-on
// - menu first flashes bcd option; enter selects it and resumes running
// - next-option from bcd steps baud rates from 19.2k; accept stores
// - then units, word/stop and parity; next cycles, accept stores
// - factory defaults 9600 baud, units on, 7 bits 2 stops, no parity
// - units code 2 is numeric only, code 1 full; code flashes till accepted
// - output formats are exactly bcd, serial numeric, serial full
// - tension is negative force; low limit is the more negative one
// - numeric-only output replaces unit text with two spaces
package gsms_pkg;

  typedef enum logic [3:0] {
    ST_OFF    = 4'b0000,
    ST_RUN    = 4'b0001,
    ST_HOLD   = 4'b0010,
    ST_ALARM  = 4'b0011,
    ST_STAND  = 4'b0100,
    ST_APD    = 4'b0101,
    ST_BCD    = 4'b0110,
    ST_BAUD   = 4'b0111,
    ST_UNITS  = 4'b1000,
    ST_WORD   = 4'b1001,
    ST_PARITY = 4'b1010
  } gsms_state_e;

  typedef enum logic [1:0] {
    FMT_BCD     = 2'b00,
    FMT_NUMERIC = 2'b01,
    FMT_FULL    = 2'b10
  } gsms_fmt_e;

  typedef struct packed {
    gsms_fmt_e   fmt;
    logic [2:0]  baud;
    logic [1:0]  units;
    logic [1:0]  word;
    logic [1:0]  parity;
  } gsms_comm_s;

  // key positions in the keypad vector
  localparam int KEY_UP    = 0;
  localparam int KEY_NEXT  = 1;
  localparam int KEY_ENTER = 2;
  localparam int KEY_SEND  = 3;
  localparam int KEY_ON    = 4;
  localparam int KEY_OFF   = 5;
  localparam int NKEYS     = 6;

  // option codes
  localparam logic [2:0] BAUD_19200 = 3'h0;
  localparam logic [2:0] BAUD_9600  = 3'h1;
  localparam logic [2:0] BAUD_LAST  = 3'h4;
  localparam logic [1:0] UNITS_FULL = 2'h1;
  localparam logic [1:0] UNITS_NUM  = 2'h2;
  localparam logic [1:0] WORD_7_2   = 2'h0;
  localparam logic [1:0] WORD_LAST  = 2'h2;
  localparam logic [1:0] PAR_NONE   = 2'h0;
  localparam logic [1:0] PAR_LAST   = 2'h2;
  localparam gsms_comm_s COMM_RST   =
    '{FMT_FULL, BAUD_9600, UNITS_FULL, WORD_7_2, PAR_NONE};

  // timing
  localparam longint unsigned CLK_HZ       = 64'd100_000_000;
  localparam longint unsigned APD_TIME_MIN = 64'd10;
  localparam longint unsigned APD_CYC      = APD_TIME_MIN * 64'd60 * CLK_HZ;
  localparam longint unsigned HOLD_TIME_S  = 64'd2;
  localparam longint unsigned HOLD_CYC     = HOLD_TIME_S * CLK_HZ;

  // register map
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_LIM_HI = 12'h004;
  localparam logic [11:0] OFS_LIM_LO = 12'h008;
  localparam logic [11:0] OFS_COMM   = 12'h00C;
  localparam logic [11:0] OFS_CTRL   = 12'h010;
  localparam logic [15:0] LIM_RST    = 16'h0000;
  localparam int CTRL_CLR_LIM = 0;

endpackage

// file: gsms_operator.sv
// operator at the keypad with the load on the cell; drives only at posedge, save the key release at time zero
module gsms_operator (
  input  wire logic                       clk_sys,   // system clock
  output logic [gsms_pkg::NKEYS-1:0]      key_pin,   // keypad levels
  output logic signed [15:0]              force_val  // load reading
);
  timeunit 1ns;
  timeprecision 1ns;

  // keys released at time zero; the bench sets the load once powered
  initial begin
    key_pin   = '0;
  end

  // change one key level just after a rising edge
  task automatic set_key(input int k, input logic v);
    @(posedge clk_sys);
    key_pin[k] <= v;
  endtask

  // new reading presented just after a rising edge
  task automatic set_force(input logic signed [15:0] v);
    @(posedge clk_sys);
    force_val <= v;
  endtask

  // long enough for the two sync flops plus the edge detector
  task automatic press(input int k);
    set_key(k, 1'b1);
    repeat (6) @(posedge clk_sys);
    key_pin[k] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // up held first, then next-option pressed, then up let go
  task automatic open_chain();
    set_key(gsms_pkg::KEY_UP, 1'b1);
    repeat (3) @(posedge clk_sys);
    press(gsms_pkg::KEY_NEXT);
    key_pin[gsms_pkg::KEY_UP] <= 1'b0;
  endtask

  // send held through power-on, then for hold_cyc more cycles
  task automatic power_on(input int hold_cyc);
    set_key(gsms_pkg::KEY_SEND, 1'b1);
    press(gsms_pkg::KEY_ON);
    repeat (hold_cyc) @(posedge clk_sys);
    key_pin[gsms_pkg::KEY_SEND] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // gsms_operator

// file: gsms_top_tb.sv
`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end

module gsms_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                          clk_sys, arst_n, load_change, comm_activity;
  logic [gsms_pkg::NKEYS-1:0]    key_pin;
  logic signed [15:0]            force_val;
  logic [11:0]                   paddr;
  logic                          psel, penable, pwrite, pready, pslverr;
  logic [31:0]                   pwdata, prdata, rd;
  gsms_pkg::gsms_state_e         disp_step;
  logic                          disp_flash, buzzer, stand_stop, err;
  logic [2:0]                    disp_option;
  logic                          gauge_power, peak_clear, units_blank;
  gsms_pkg::gsms_comm_s          comm_cfg, exp_cfg;
  int                            n_fail, total_checks, n_clear;
  logic signed [15:0]            lim_v [5] = '{16'sd100, 16'sd99,
                                     -16'sd100, -16'sd99, 16'sh7FFF};
  logic                          lim_hit [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  // short counts keep the idle and hold timers quick
  gsms_top #(.APD_CYCLES(36'd200), .HOLD_CYCLES(28'd20)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .key_pin(key_pin),
    .force_val(force_val), .load_change(load_change),
    .comm_activity(comm_activity), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .disp_step(disp_step),
    .disp_flash(disp_flash), .disp_option(disp_option), .buzzer(buzzer),
    .stand_stop(stand_stop), .gauge_power(gauge_power),
    .peak_clear(peak_clear), .units_blank(units_blank), .comm_cfg(comm_cfg));

  gsms_operator i_op (.clk_sys(clk_sys), .key_pin(key_pin),
                      .force_val(force_val));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // count wipe pulses; the flop output is stable when the edge samples it
  always @(posedge clk_sys) begin
    if (peak_clear === 1'b1) n_clear++;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one apb transfer; the answer is read at the edge that ends the access
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // press then look at the outputs once they have settled
  task automatic key(input int k);
    i_op.press(k);
    @(negedge clk_sys);
  endtask

  // bounded wait for the power output to reach a level
  task automatic wait_power(input logic v, input int max);
    for (int i = 0; i < max && gauge_power !== v; i++) @(negedge clk_sys);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // hang guard, well beyond the roughly 1300 cycles the run needs
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  // main sequence
  initial begin
    {arst_n, load_change, comm_activity, psel} = '0;
    {n_fail, total_checks, n_clear} = '0;
    exp_cfg = '{gsms_pkg::FMT_NUMERIC, 3'h2, gsms_pkg::UNITS_NUM, 2'h1, 2'h1};
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    `CHK("comm reset", gsms_pkg::COMM_RST, comm_cfg);
    `CHK("power reset", 1'b0, gauge_power);
    key(gsms_pkg::KEY_ON);
    `CHK("run step", gsms_pkg::ST_RUN, disp_step);
    // without limits the chain stays shut and the buzzer quiet
    i_op.set_force(16'sh7FFF);
    i_op.open_chain();
    idle(1);
    `CHK("refused", gsms_pkg::ST_RUN, disp_step);
    `CHK("quiet", 1'b0, buzzer);
    apb(1'b1, gsms_pkg::OFS_LIM_HI, 32'h0000_0064);
    apb(1'b1, gsms_pkg::OFS_LIM_LO, 32'h0000_FF9C);
    apb(1'b0, gsms_pkg::OFS_LIM_HI, 32'h0000_0000);
    `CHK("lim hi", 32'h0001_0064, rd);
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err);
    `CHK("unmapped rd", 32'h0000_0000, rd);
    apb(1'b1, gsms_pkg::OFS_COMM, 32'h0000_0000);
    apb(1'b0, gsms_pkg::OFS_COMM, 32'h0000_0000);
    `CHK("comm ro", {21'h0, gsms_pkg::COMM_RST}, rd);
    i_op.set_force(16'sh0000);
    // chain with every feature switched on
    i_op.open_chain();
    idle(1);
    `CHK("alarm", gsms_pkg::ST_ALARM, disp_step);
    `CHK("alarm flash", 1'b1, disp_flash);
    key(gsms_pkg::KEY_ENTER);
    `CHK("stand", gsms_pkg::ST_STAND, disp_step);
    `CHK("stand flash", 1'b1, disp_flash);
    key(gsms_pkg::KEY_ENTER);
    `CHK("apd", gsms_pkg::ST_APD, disp_step);
    `CHK("apd flash", 1'b1, disp_flash);
    key(gsms_pkg::KEY_ENTER);
    `CHK("chain end", gsms_pkg::ST_RUN, disp_step);
    apb(1'b0, gsms_pkg::OFS_STATUS, 32'h0000_0000);
    `CHK("enables", 3'b111, rd[2:0]);
    // limit edges on both sides
    for (int i = 0; i < 5; i++) begin
      i_op.set_force(lim_v[i]);
      idle(3);
      `CHK("buzzer", lim_hit[i], buzzer);
      `CHK("stop", lim_hit[i], stand_stop);
    end
    i_op.set_force(16'sh0000);
    // activity restarts the idle interval, then it runs out
    idle(150);
    @(posedge clk_sys);
    load_change <= 1'b1;
    @(posedge clk_sys);
    load_change <= 1'b0;
    idle(150);
    @(posedge clk_sys);
    comm_activity <= 1'b1;
    @(posedge clk_sys);
    comm_activity <= 1'b0;
    idle(150);
    `CHK("still on", 1'b1, gauge_power);
    wait_power(1'b0, 100);
    `CHK("auto off", 1'b0, gauge_power);
    idle(3);
    `CHK("peaks wiped", 1, n_clear);
    // chain with every feature switched off
    key(gsms_pkg::KEY_ON);
    i_op.open_chain();
    key(gsms_pkg::KEY_NEXT);
    `CHK("stand steady", gsms_pkg::ST_STAND, disp_step);
    `CHK("steady", 1'b0, disp_flash);
    key(gsms_pkg::KEY_NEXT);
    `CHK("apd steady", gsms_pkg::ST_APD, disp_step);
    `CHK("steady", 1'b0, disp_flash);
    key(gsms_pkg::KEY_NEXT);
    `CHK("chain end", gsms_pkg::ST_RUN, disp_step);
    i_op.set_force(16'sd100);
    idle(3);
    `CHK("no buzz", 1'b0, buzzer);
    `CHK("no stop", 1'b0, stand_stop);
    i_op.set_force(16'sh0000);
    idle(300);
    `CHK("apd off", 1'b1, gauge_power);
    key(gsms_pkg::KEY_OFF);
    `CHK("off key", 1'b0, gauge_power);
    `CHK("peaks wiped", 2, n_clear);
    // short send hold gives normal running, long hold the menu
    i_op.power_on(0);
    idle(1);
    `CHK("short hold", gsms_pkg::ST_RUN, disp_step);
    key(gsms_pkg::KEY_OFF);
    i_op.power_on(30);
    idle(1);
    `CHK("bcd", gsms_pkg::ST_BCD, disp_step);
    `CHK("bcd flash", 1'b1, disp_flash);
    key(gsms_pkg::KEY_ENTER);
    `CHK("bcd run", gsms_pkg::ST_RUN, disp_step);
    `CHK("bcd fmt", gsms_pkg::FMT_BCD, comm_cfg.fmt);
    key(gsms_pkg::KEY_OFF);
    i_op.power_on(30);
    key(gsms_pkg::KEY_NEXT);
    `CHK("baud", gsms_pkg::ST_BAUD, disp_step);
    `CHK("baud first", gsms_pkg::BAUD_19200, disp_option);
    key(gsms_pkg::KEY_NEXT);
    key(gsms_pkg::KEY_NEXT);
    `CHK("baud step", 3'h2, disp_option);
    key(gsms_pkg::KEY_SEND);
    `CHK("units", gsms_pkg::ST_UNITS, disp_step);
    `CHK("baud kept", 3'h2, comm_cfg.baud);
    key(gsms_pkg::KEY_NEXT);
    `CHK("units code", {1'b0, gsms_pkg::UNITS_NUM}, disp_option);
    `CHK("units flash", 1'b1, disp_flash);
    key(gsms_pkg::KEY_ENTER);
    `CHK("word", gsms_pkg::ST_WORD, disp_step);
    `CHK("blank", 1'b1, units_blank);
    `CHK("num fmt", gsms_pkg::FMT_NUMERIC, comm_cfg.fmt);
    key(gsms_pkg::KEY_NEXT);
    key(gsms_pkg::KEY_SEND);
    `CHK("parity", gsms_pkg::ST_PARITY, disp_step);
    key(gsms_pkg::KEY_NEXT);
    key(gsms_pkg::KEY_ENTER);
    `CHK("menu end", gsms_pkg::ST_RUN, disp_step);
    `CHK("comm cfg", exp_cfg, comm_cfg);
    key(gsms_pkg::KEY_OFF);
    key(gsms_pkg::KEY_ON);
    `CHK("comm kept", exp_cfg, comm_cfg);
    apb(1'b1, gsms_pkg::OFS_CTRL, 32'h0000_0001);
    apb(1'b0, gsms_pkg::OFS_LIM_HI, 32'h0000_0000);
    `CHK("set flag clear", 1'b0, rd[16]);
    complete_run();
  end
endmodule // gsms_top_tb
